// file: verilog/rgr_pkg.sv
package rgr_pkg;
    // Clock
    localparam int unsigned CLK_PERIOD_NS = 100;
    // Pin filter timing
    localparam int unsigned FILT_TC_NS = 12000;
    localparam int unsigned FILT_GUARANTEE_NS = 26000;
    localparam int unsigned FILT_REJECT_NS = 1000;
    localparam int unsigned FILT_CYCLES = FILT_TC_NS / CLK_PERIOD_NS;
    localparam int unsigned FILT_CNT_W = 8;
    // Config check retries
    localparam logic [1:0] CFG_MAX_FAILS = 2'h3;
    // Register offsets
    localparam logic [3:0] REG_CAUSE = 4'h0;
    localparam logic [3:0] REG_CTRL = 4'h4;
    localparam logic [3:0] REG_STATE = 4'h8;
    // Cause field positions
    localparam int unsigned CAUSE_AON = 0;
    localparam int unsigned CAUSE_LV = 1;
    localparam int unsigned CAUSE_PIN = 2;
    localparam int unsigned CAUSE_WDOG = 3;
    localparam int unsigned CAUSE_SOFT = 4;
    localparam int unsigned CAUSE_WAKE = 5;
    localparam int unsigned CAUSE_CFG = 6;
    localparam int unsigned CAUSE_LOCK = 7;
    localparam int unsigned CAUSE_W = 8;
    localparam logic [CAUSE_W-1:0] CAUSE_RESET = 8'h01;
    // Control fields
    localparam int unsigned CTRL_LOCK_CLR = 0;
    // Reset vector bits: full, cpu, dap, retained, volatile
    localparam int unsigned RV_FULL = 4;
    localparam int unsigned RV_CPU = 3;
    localparam int unsigned RV_DAP = 2;
    localparam int unsigned RV_RET = 1;
    localparam int unsigned RV_VOL = 0;
    localparam logic [4:0] RV_ALL = 5'h1f;
    localparam logic [4:0] RV_NO_DAP = 5'h1b;
    localparam logic [4:0] RV_NO_RET = 5'h1d;
    localparam logic [4:0] RV_CPU_PERI = 5'h0b;
    localparam logic [4:0] RV_CFG = 5'h19;
    localparam logic [4:0] RV_EMU = 5'h09;
    localparam logic [4:0] RV_DBG = 5'h08;
    localparam logic [4:0] RV_NONE = 5'h00;
endpackage

// file: verilog/rgr_sync_if.sv
`timescale 1ns/1ps
// Raw reset request vector toward the release synchroniser
interface rgr_sync_if;
    logic [4:0] req;
    logic [4:0] rst;
    modport gen (output req, input rst);
    modport sync (input req, output rst);
endinterface

// file: verilog/rgr_rst_sync.sv
`timescale 1ns/1ps
// Async assert, two-stage synchronous release, one per reset output
module rgr_rst_sync (
    // Clock
    input wire logic clk,
    // Request vector
    rgr_sync_if.sync bus
);
    import rgr_pkg::*;

    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : g_ch
            logic s1;
            logic s2;
            logic next_s1;
            logic next_s2;
            // Next values: shift zeros in once request drops
            always_comb begin
                next_s1 = 1'b1;
                next_s2 = s1;
                if (!bus.req[g]) begin
                    next_s1 = 1'b0;
                end
            end
            // Asserts at once on request, releases two edges later
            always_ff @(posedge clk or posedge bus.req[g]) begin
                if (bus.req[g]) begin
                    s1 <= 1'b1;
                    s2 <= 1'b1;
                end else begin
                    s1 <= next_s1;
                    s2 <= next_s2;
                end
            end
            assign bus.rst[g] = s2;
        end
    endgenerate
endmodule

// file: verilog/rgr_reset_gen.sv
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
// Central reset generation and restart cause recording
module rgr_reset_gen (
    // Clock and reset
    input wire logic I_REF_CLK,
    input wire logic I_SYS_RST,
    // Supply monitors and pin
    input wire logic i_always_on_supply_monitor_reset,
    input wire logic i_core_supply_monitor_reset,
    input wire logic i_memory_supply_monitor_reset,
    input wire logic i_external_reset_pin_n,
    // Event sources
    input wire logic i_watchdog_expired,
    input wire logic i_cpu_soft_reset_request,
    input wire logic i_config_check_fail_source,
    input wire logic i_debug_port_reset_request,
    input wire logic i_cpu_lockup,
    // Power manager
    input wire logic i_deep_sleep_active,
    input wire logic i_deep_sleep_emulated,
    // Test port reset and debug mode
    input wire logic i_test_port_reset_input,
    input wire logic i_serial_wire_mode,
    input wire logic i_combined_debug_port_enable,
    // Register port
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Reset outputs
    output logic o_full_core_reset,
    output logic o_cpu_only_reset,
    output logic o_debug_access_port_reset,
    output logic o_retained_periph_reset,
    output logic o_volatile_periph_reset,
    output logic o_test_port_reset,
    output logic o_readout_protect_force,
    output logic o_emulated_sleep_req
);
    import rgr_pkg::*;

    // Pin and asynchronous event synchronisers
    logic [6:0] sy1;
    logic [6:0] sy2;
    logic [6:0] next_sy1;
    logic [6:0] next_sy2;
    logic [6:0] raw_in;
    assign raw_in = {i_cpu_lockup, i_deep_sleep_emulated, i_deep_sleep_active,
                     i_test_port_reset_input, i_serial_wire_mode,
                     i_combined_debug_port_enable, i_external_reset_pin_n};
    always_comb begin
        next_sy1 = raw_in;
        next_sy2 = sy1;
    end
    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            sy1 <= 7'h03; // Idle levels: pin high, debug port enabled
            sy2 <= 7'h03;
        end else begin
            sy1 <= next_sy1;
            sy2 <= next_sy2;
        end
    end
    logic pin_n_s;
    logic dbg_en_s;
    logic swd_s;
    logic tprst_s;
    logic sleep_s;
    logic emu_s;
    logic lock_s;
    assign pin_n_s = sy2[0];
    assign dbg_en_s = sy2[1];
    assign swd_s = sy2[2];
    assign tprst_s = sy2[3];
    assign sleep_s = sy2[4];
    assign emu_s = sy2[5];
    assign lock_s = sy2[6];

    // Pin filter: integrating counter with hysteresis
    logic [FILT_CNT_W-1:0] filt_cnt;
    logic [FILT_CNT_W-1:0] next_filt_cnt;
    logic pin_rst;
    logic next_pin_rst;
    localparam logic [FILT_CNT_W-1:0] FILT_MAX = FILT_CNT_W'(FILT_CYCLES);
    // Filter count must fit its counter
    if (FILT_CYCLES >= (1 << FILT_CNT_W)) begin : g_filt_chk
        $error("filter count too wide for counter");
    end
    always_comb begin
        next_filt_cnt = filt_cnt;
        next_pin_rst = pin_rst;
        if (!pin_n_s) begin
            if (filt_cnt != FILT_MAX) begin
                next_filt_cnt = filt_cnt + 1'b1;
            end
        end else if (filt_cnt != '0) begin
            next_filt_cnt = filt_cnt - 1'b1;
        end
        if (filt_cnt == FILT_MAX) begin
            next_pin_rst = 1'b1;
        end else if (filt_cnt == '0) begin
            next_pin_rst = 1'b0;
        end
    end
    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            filt_cnt <= '0;
            pin_rst <= 1'b0;
        end else begin
            filt_cnt <= next_filt_cnt;
            pin_rst <= next_pin_rst;
        end
    end

    // Low-voltage source merge
    logic lv_rst;
    assign lv_rst = i_core_supply_monitor_reset | i_memory_supply_monitor_reset;

    // Sleep tracking: normal sleep wake marks low-voltage reset as a wake
    logic in_sleep;
    logic next_in_sleep;
    logic lv_wake;
    logic next_lv_wake;
    always_comb begin
        next_in_sleep = sleep_s & ~emu_s;
        next_lv_wake = lv_wake;
        if (sleep_s && !emu_s) begin
            next_lv_wake = 1'b1;
        end else if (!lv_rst && !in_sleep) begin
            next_lv_wake = 1'b0;
        end
    end
    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            in_sleep <= 1'b0;
            lv_wake <= 1'b0;
        end else begin
            in_sleep <= next_in_sleep;
            lv_wake <= next_lv_wake;
        end
    end

    // Config check retries and emulated sleep lockout
    logic [1:0] cfg_fails;
    logic [1:0] next_cfg_fails;
    logic cfg_prev;
    logic next_cfg_prev;
    logic cfg_stop;
    logic next_cfg_stop;
    logic cfg_rst;
    always_comb begin
        next_cfg_prev = i_config_check_fail_source;
        next_cfg_fails = cfg_fails;
        next_cfg_stop = cfg_stop;
        if (i_config_check_fail_source && !cfg_prev && !cfg_stop) begin
            next_cfg_fails = cfg_fails + 2'h1;
            if (cfg_fails + 2'h1 == CFG_MAX_FAILS) begin
                next_cfg_stop = 1'b1;
            end
        end
    end
    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            cfg_fails <= 2'h0;
            cfg_prev <= 1'b0;
            cfg_stop <= 1'b0;
        end else begin
            cfg_fails <= next_cfg_fails;
            cfg_prev <= next_cfg_prev;
            cfg_stop <= next_cfg_stop;
        end
    end
    // Restart request while the source is held and retries remain; afterwards emulated sleep holds
    // Third failure goes straight to emulated sleep, no further restart
    assign cfg_rst = i_config_check_fail_source & ~cfg_stop & ~next_cfg_stop;

    // Source to output mapping; async sources feed the vector directly
    logic [4:0] req;
    always_comb begin
        req = RV_NONE;
        if (i_always_on_supply_monitor_reset) begin
            req = req | RV_ALL;
        end
        if (lv_rst) begin
            req = req | (lv_wake ? RV_NO_RET : RV_ALL);
        end
        if (pin_rst) begin
            req = req | RV_NO_DAP;
        end
        if (i_watchdog_expired) begin
            req = req | RV_CPU_PERI;
        end
        if (i_cpu_soft_reset_request) begin
            req = req | RV_CPU_PERI;
        end
        if (cfg_rst) begin
            req = req | RV_CFG;
        end
        if (i_debug_port_reset_request) begin
            req = req | RV_DBG;
        end
        if (in_sleep) begin
            req = req | RV_NO_RET;
        end
        if ((sleep_s && emu_s) || cfg_stop) begin
            req = req | RV_EMU;
        end
    end

    // Release synchroniser
    rgr_sync_if sbus ();
    assign sbus.req = req;
    rgr_rst_sync u_sync (
        .clk(I_REF_CLK),
        .bus(sbus.sync)
    );

    // Output flops, re-asserted asynchronously with each request bit
    logic [4:0] rst_q;
    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : g_out
            always_ff @(posedge I_REF_CLK or posedge req[g]) begin
                if (req[g]) begin
                    rst_q[g] <= 1'b1;
                end else begin
                    rst_q[g] <= sbus.rst[g];
                end
            end
        end
    endgenerate
    // Full reset covers debug parts except on pin and config failure requests; cpu-only spares them
    assign o_full_core_reset = rst_q[RV_FULL];
    assign o_cpu_only_reset = rst_q[RV_CPU];
    assign o_debug_access_port_reset = rst_q[RV_DAP];
    assign o_retained_periph_reset = rst_q[RV_RET];
    assign o_volatile_periph_reset = rst_q[RV_VOL];

    // Cause recording, lockup flag, register port
    logic [CAUSE_W-1:0] cause;
    logic [CAUSE_W-1:0] next_cause;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic tp_rst;
    logic next_tp_rst;
    logic rp_force;
    logic next_rp_force;
    // Restart sources standing in this cycle
    logic [4:0] src_now;
    always_comb begin
        src_now = {cfg_rst, i_cpu_soft_reset_request, i_watchdog_expired,
                   pin_rst, i_always_on_supply_monitor_reset | lv_rst};
        next_cause = cause;
        // A standing source replaces the record; all fields taken in one cycle
        if (|src_now) begin
            next_cause = '0;
            next_cause[CAUSE_AON] = i_always_on_supply_monitor_reset;
            next_cause[CAUSE_LV] = lv_rst & ~lv_wake;
            next_cause[CAUSE_WAKE] = lv_rst & lv_wake;
            next_cause[CAUSE_PIN] = src_now[1];
            next_cause[CAUSE_WDOG] = src_now[2];
            next_cause[CAUSE_SOFT] = src_now[3];
            next_cause[CAUSE_CFG] = src_now[4];
        end
        if (i_wr && i_addr == REG_CTRL && i_wdata[CTRL_LOCK_CLR]) begin
            next_cause[CAUSE_LOCK] = 1'b0;
        end
        if (lock_s) begin
            next_cause[CAUSE_LOCK] = 1'b1;
        end
        next_tp_rst = tprst_s & ~swd_s & dbg_en_s;
        next_rp_force = cfg_stop;
        next_rdata = 32'h0;
        if (i_rd) begin
            case (i_addr)
                REG_CAUSE: next_rdata = {24'h0, cause};
                REG_STATE: next_rdata = {27'h0, cfg_stop, cfg_fails, in_sleep, lv_wake};
                default: next_rdata = 32'h0;
            endcase
        end
    end
    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            cause <= CAUSE_RESET;
            rdata <= 32'h0;
            tp_rst <= 1'b0;
            rp_force <= 1'b0;
        end else begin
            cause <= next_cause;
            rdata <= next_rdata;
            tp_rst <= next_tp_rst;
            rp_force <= next_rp_force;
        end
    end
    assign o_rdata = rdata;
    assign o_test_port_reset = tp_rst;
    assign o_readout_protect_force = rp_force;
    assign o_emulated_sleep_req = rp_force;

    // Checks
    wdog_map_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
        i_watchdog_expired && req[RV_FULL] == 1'b0 |-> !req[RV_DAP])
        else $error("watchdog drove access port reset");
    dbg_map_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
        req == RV_DBG |-> ##2 o_cpu_only_reset && !o_full_core_reset)
        else $error("debug reset map wrong");
    pin_keep_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
        $rose(pin_rst) |-> $past(filt_cnt) == FILT_MAX)
        else $error("pin reset without full filter count");
    cfg_stop_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
        $rose(cfg_stop) |-> cfg_fails == CFG_MAX_FAILS)
        else $error("retry stop count wrong");
    rp_force_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
        cfg_stop |-> ##1 o_readout_protect_force)
        else $error("readout protection not forced");
    tport_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
        swd_s |-> ##1 !o_test_port_reset)
        else $error("test port reset in serial-wire mode");
    tport_off_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
        !dbg_en_s |-> ##1 !o_test_port_reset)
        else $error("test port reset with debug port disabled");
    lock_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
        lock_s && req == RV_NONE |-> ##1 cause[CAUSE_LOCK] && req == RV_NONE)
        else $error("lockup flag missing");
    aon_all_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
        i_always_on_supply_monitor_reset |-> req == RV_ALL)
        else $error("always-on supply reset incomplete");
    rel_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
        !req[RV_CPU] [*4] |-> !o_cpu_only_reset)
        else $error("cpu reset not released");
    emu_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
        cfg_stop && !in_sleep && !lv_rst && !pin_rst && !i_always_on_supply_monitor_reset
        && !i_debug_port_reset_request && !i_watchdog_expired && !i_cpu_soft_reset_request
        |-> !req[RV_RET] && !req[RV_DAP])
        else $error("emulated sleep map wrong");
    sleep_map_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
        in_sleep |-> (req & RV_NO_RET) == RV_NO_RET)
        else $error("normal sleep reset map incomplete");
    cfg_map_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
        cfg_rst |-> (req & RV_CFG) == RV_CFG)
        else $error("config failure reset map incomplete");
    pin_cv: cover property (@(posedge I_REF_CLK) disable iff (I_SYS_RST) $rose(pin_rst));
    stop_cv: cover property (@(posedge I_REF_CLK) disable iff (I_SYS_RST) $rose(cfg_stop));
    wake_cv: cover property (@(posedge I_REF_CLK) disable iff (I_SYS_RST) lv_rst && lv_wake);
    emu_cv: cover property (@(posedge I_REF_CLK) disable iff (I_SYS_RST) sleep_s && emu_s);
    dbg_cv: cover property (@(posedge I_REF_CLK) disable iff (I_SYS_RST) req == RV_DBG);
endmodule

// file: sim/rgr_far_model.sv
`timescale 1ns/1ps
// Far side: supplies, pin, event senders, power manager and debug host
module rgr_far_model (
    // Clock
    input wire logic i_clk,
    // Source levels, one bit per sender
    output logic [13:0] o_src,
    output logic o_pin_n,
    output logic o_dp_en
);
    // All senders idle inactive
    initial begin
        o_src = 14'h0000;
    end
    // Pin is pulled high whenever nobody holds it low
    assign o_pin_n = ~o_src[3];
    assign o_dp_en = ~o_src[13];
    // Debug host sets and clears its request bit like any other level
    task automatic drive(input int idx, input logic val);
        @(posedge i_clk);
        o_src[idx] <= val;
    endtask
endmodule

// file: sim/tb_reset_generation_and_recording.sv
`timescale 1ns/1ps
// Self-checking bench for the reset generator
module tb_reset_generation_and_recording;
    import rgr_pkg::*;
    logic I_REF_CLK;
    logic I_SYS_RST;
    logic [3:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic wr;
    logic rd;
    logic [13:0] src;
    logic pin_n;
    logic dp_en;
    logic full, cpu, dap, ret, vol, tap, rdp, emreq;
    logic [4:0] outs;
    int error_cnt;
    int cmp_count;
    assign outs = {full, cpu, dap, ret, vol};

    rgr_far_model u_far (.i_clk(I_REF_CLK), .o_src(src), .o_pin_n(pin_n), .o_dp_en(dp_en));

    rgr_reset_gen u_dut (
        .I_REF_CLK(I_REF_CLK), .I_SYS_RST(I_SYS_RST),
        .i_always_on_supply_monitor_reset(src[0]), .i_core_supply_monitor_reset(src[1]),
        .i_memory_supply_monitor_reset(src[2]), .i_external_reset_pin_n(pin_n),
        .i_watchdog_expired(src[4]), .i_cpu_soft_reset_request(src[5]),
        .i_config_check_fail_source(src[6]), .i_debug_port_reset_request(src[7]),
        .i_cpu_lockup(src[8]), .i_deep_sleep_active(src[9]), .i_deep_sleep_emulated(src[10]),
        .i_test_port_reset_input(src[11]), .i_serial_wire_mode(src[12]),
        .i_combined_debug_port_enable(dp_en), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .o_full_core_reset(full), .o_cpu_only_reset(cpu),
        .o_debug_access_port_reset(dap), .o_retained_periph_reset(ret),
        .o_volatile_periph_reset(vol), .o_test_port_reset(tap),
        .o_readout_protect_force(rdp), .o_emulated_sleep_req(emreq)
    );

    // Clock at 10 MHz
    initial begin
        I_REF_CLK = 1'b0;
        forever #50 I_REF_CLK = ~I_REF_CLK;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge I_REF_CLK);
    endtask

    // One-cycle read strobe; data stands in the following cycle only
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge I_REF_CLK);
        rd <= 1'b1;
        addr <= a;
        @(posedge I_REF_CLK);
        rd <= 1'b0;
        @(negedge I_REF_CLK);
        d = rdata;
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge I_REF_CLK);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge I_REF_CLK);
        wr <= 1'b0;
    endtask

    // Bounded wait for the five vector reset outputs (full, cpu, dap, retained, volatile) to release
    task automatic wait_idle();
        int n;
        n = 0;
        while (outs !== 5'h00 && n < 300) begin
            @(negedge I_REF_CLK);
            n++;
        end
        if (n == 300) begin
            error_cnt++;
            $display("MISMATCH t=%0t reset outputs never released", $time);
            report_and_stop();
        end
    endtask

    task automatic do_reset();
        @(posedge I_REF_CLK);
        I_SYS_RST <= 1'b1;
        repeat (12) @(posedge I_REF_CLK);
        I_SYS_RST <= 1'b0;
        cycles(2);
    endtask

    // Hold one source, compare the reset map, release, compare recorded cause
    task automatic apply(input int idx, input logic [4:0] exp, input logic [7:0] cexp,
                         input bit use_cause);
        logic [31:0] d;
        u_far.drive(idx, 1'b1);
        cycles(6);
        chk({27'h0, outs}, {27'h0, exp});
        u_far.drive(idx, 1'b0);
        @(negedge I_REF_CLK);
        chk({27'h0, outs}, {27'h0, exp});
        wait_idle();
        if (use_cause) begin
            reg_rd(REG_CAUSE, d);
            chk(d, {24'h0, cexp});
        end
    endtask

    task automatic t_map();
        apply(0, RV_ALL, 8'h01, 1'b1);
        apply(2, RV_ALL, 8'h02, 1'b1);
        apply(4, RV_CPU_PERI, 8'h08, 1'b1);
        apply(5, RV_CPU_PERI, 8'h10, 1'b1);
        apply(7, RV_DBG, 8'h00, 1'b0);
        u_far.drive(10, 1'b1);
        apply(9, RV_EMU, 8'h00, 1'b0);
        u_far.drive(10, 1'b0);
        $display("test source map done");
    endtask

    task automatic t_pin();
        logic seen;
        logic [31:0] d;
        seen = 1'b0;
        u_far.drive(3, 1'b1);
        repeat (FILT_REJECT_NS / CLK_PERIOD_NS - 1) @(posedge I_REF_CLK);
        u_far.drive(3, 1'b0);
        repeat (30) begin
            @(negedge I_REF_CLK);
            seen = seen | full | cpu;
        end
        chk({31'h0, seen}, 32'h0);
        cycles(20);
        u_far.drive(3, 1'b1);
        repeat (FILT_GUARANTEE_NS / CLK_PERIOD_NS) @(posedge I_REF_CLK);
        @(negedge I_REF_CLK);
        chk({27'h0, outs}, {27'h0, RV_NO_DAP});
        u_far.drive(3, 1'b0);
        wait_idle();
        reg_rd(REG_CAUSE, d);
        chk(d, 32'h04);
        $display("test pin filter done");
    endtask

    task automatic t_lock();
        logic [31:0] d;
        u_far.drive(8, 1'b1);
        cycles(6);
        chk({27'h0, outs}, 32'h0);
        reg_rd(REG_CAUSE, d);
        chk({31'h0, d[CAUSE_LOCK]}, 32'h1);
        u_far.drive(8, 1'b0);
        cycles(4);
        reg_wr(REG_CTRL, 32'h1);
        reg_rd(REG_CAUSE, d);
        chk({31'h0, d[CAUSE_LOCK]}, 32'h0);
        reg_rd(4'hc, d);
        chk(d, 32'h0);
        $display("test lockup done");
    endtask

    task automatic t_tap();
        for (int m = 0; m < 3; m++) begin
            if (m > 0) begin
                u_far.drive(11 + m, 1'b1);
            end
            u_far.drive(11, 1'b1);
            cycles(6);
            chk({31'h0, tap}, {31'h0, m == 0});
            chk({27'h0, outs}, 32'h0);
            u_far.drive(11, 1'b0);
            if (m > 0) begin
                u_far.drive(11 + m, 1'b0);
            end
            cycles(6);
        end
        $display("test test port reset done");
    endtask

    task automatic t_wake();
        logic [31:0] d;
        u_far.drive(9, 1'b1);
        cycles(6);
        chk({27'h0, outs}, {27'h0, RV_NO_RET});
        u_far.drive(1, 1'b1);
        cycles(2);
        u_far.drive(9, 1'b0);
        cycles(6);
        chk({27'h0, outs}, {27'h0, RV_NO_RET});
        u_far.drive(1, 1'b0);
        wait_idle();
        reg_rd(REG_CAUSE, d);
        chk({31'h0, d[CAUSE_WAKE]}, 32'h1);
        $display("test sleep wake done");
    endtask

    task automatic t_cfg();
        logic [31:0] d;
        do_reset();
        for (int k = 1; k <= 3; k++) begin
            u_far.drive(6, 1'b1);
            cycles(6);
            chk({27'h0, outs}, {27'h0, (k < 3) ? RV_CFG : RV_EMU});
            u_far.drive(6, 1'b0);
            if (k < 3) begin
                wait_idle();
                chk({31'h0, emreq}, 32'h0);
            end
        end
        cycles(8);
        chk({27'h0, outs}, {27'h0, RV_EMU});
        chk({31'h0, emreq}, 32'h1);
        chk({31'h0, rdp}, 32'h1);
        reg_rd(REG_STATE, d);
        chk(d, 32'h1c);
        do_reset();
        wait_idle();
        chk({31'h0, rdp}, 32'h0);
        $display("test config retry done");
    endtask

    // Main sequence
    initial begin
        error_cnt = 0;
        cmp_count = 0;
        I_SYS_RST = 1'b1;
        addr = 4'h0;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        repeat (12) @(posedge I_REF_CLK);
        I_SYS_RST <= 1'b0;
        cycles(2);
        t_map();
        t_pin();
        t_lock();
        t_tap();
        t_wake();
        t_cfg();
        report_and_stop();
    end
endmodule
